// ==== rtl/pfsf_pkg.sv ====
// pfsf_pkg: offsets, field positions and reset values of the status flag bank
// assumes: imported by pfsf_status and the bench; pfsf_flag does not use it
package pfsf_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] PFSF_OFS_PRIMARY = 8'h02;
  localparam logic [7:0] PFSF_OFS_SECONDARY = 8'h03;
  localparam logic [7:0] PFSF_RST_VAL = 8'h00;
  // ==========================================================================
  // primary register fields
  localparam int PFSF_B_BROWNOUT = 7;
  localparam int PFSF_B_TSD = 6;
  localparam int PFSF_B_HOT = 5;
  localparam int PFSF_B_MAIN_LOCK = 4;
  localparam int PFSF_B_CONV_LOCK = 3;
  localparam int PFSF_B_USB_LOCK = 2;
  localparam int PFSF_B_USB1 = 1;
  localparam int PFSF_B_USB2 = 0;
  // ==========================================================================
  // secondary register fields
  localparam int PFSF_B_UVD_HI = 5;
  localparam int PFSF_B_UVD_LO = 3;
  localparam int PFSF_B_PG_HI = 2;
  localparam int PFSF_B_PG_LO = 0;
  localparam logic [7:0] PFSF_RC_MASK2 = 8'h38;
endpackage

// ==== rtl/pfsf_flag.sv ====
// pfsf_flag: one latched clear-on-read fault flag
// assumes: fault level synchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module pfsf_flag (
  input wire logic i_sys_clk, // system clock
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic i_ce, // clock enable
  input wire logic i_fault, // raw fault level
  input wire logic i_clr, // read clear pulse
  output logic o_flag // latched flag
);
  logic flag_r;
  logic flag_nxt;
  // set wins over the read clear
  always_comb begin
    flag_nxt = flag_r;
    if (i_clr) begin
      flag_nxt = 1'b0;
    end
    if (i_fault) begin
      flag_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flag_r <= 1'b0;
    end else if (i_ce) begin
      flag_r <= flag_nxt;
    end
  end
  assign o_flag = flag_r;
endmodule // pfsf_flag
`default_nettype wire

// ==== rtl/pfsf_status.sv ====
// pfsf_status: two status registers and the open-drain event output
// assumes: host register reads arrive as a one-cycle read strobe with an address,
// fault levels are synchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - primary status at 0x02, read-only, reset zero
// - brownout flag sets on low input supply
// - thermal shutdown and early warning flags
// - three input lockout flags in primary
// - one fault flag per USB switch
// - reading primary clears all its flags whose faults are gone
// - event output released after both read
// - secondary D5..D3 converter undervoltage, D7..D6 zero
// - only D5..D3 of secondary clear on read
// - secondary status at offset 0x03
module pfsf_status
  import pfsf_pkg::*;
(
  input wire logic i_sys_clk, // system clock, 200 MHz
  input wire logic i_sys_rst, // synchronous reset, high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic i_rd, // register read strobe
  input wire logic [7:0] i_addr, // register offset
  input wire logic i_brownout, // input supply below brownout level
  input wire logic i_thermal_shutdown, // thermal shutdown active
  input wire logic i_thermal_warning, // temperature near shutdown
  input wire logic [2:0] i_lockout, // main, converter, usb input lockout
  input wire logic [1:0] i_usb_fault, // usb switch 1, 2 overcurrent
  input wire logic [2:0] i_conv_uv, // converter 1..3 undervoltage
  input wire logic [2:0] i_conv_pg, // converter 1..3 power good
  output logic [7:0] o_rdata, // read data, registered
  output logic o_event_oe, // event pin driven low while high
  output logic o_event_o // event pin output level, always low
);
  // ==========================================================================
  // flag bank
  logic [7:0] fault_raw;
  logic [7:0] fault_status_primary;
  logic [2:0] uv_flags;
  logic [2:0] pg_r;
  logic [2:0] pg_nxt;
  logic rd_pri;
  logic rd_sec;
  assign rd_pri = i_rd && (i_addr == PFSF_OFS_PRIMARY);
  assign rd_sec = i_rd && (i_addr == PFSF_OFS_SECONDARY);
  always_comb begin
    fault_raw = PFSF_RST_VAL;
    fault_raw[PFSF_B_BROWNOUT] = i_brownout;
    fault_raw[PFSF_B_TSD] = i_thermal_shutdown;
    fault_raw[PFSF_B_HOT] = i_thermal_warning;
    fault_raw[PFSF_B_MAIN_LOCK] = i_lockout[2];
    fault_raw[PFSF_B_CONV_LOCK] = i_lockout[1];
    fault_raw[PFSF_B_USB_LOCK] = i_lockout[0];
    fault_raw[PFSF_B_USB1] = i_usb_fault[1];
    fault_raw[PFSF_B_USB2] = i_usb_fault[0];
  end
  for (genvar g = 0; g < 8; g++) begin : g_pri
    pfsf_flag u_flag (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_fault(fault_raw[g]),
      .i_clr(rd_pri),
      .o_flag(fault_status_primary[g])
    );
  end
  // converter undervoltage flags clear on read
  for (genvar g = 0; g < 3; g++) begin : g_uv
    pfsf_flag u_flag (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_ce(i_ce),
      .i_fault(i_conv_uv[g]),
      .i_clr(rd_sec),
      .o_flag(uv_flags[g])
    );
  end
  // power good follows its converter, not cleared by reads
  always_comb begin
    pg_nxt = i_conv_pg;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pg_r <= 3'h0;
    end else if (i_ce) begin
      pg_r <= pg_nxt;
    end
  end
  // ==========================================================================
  // read data and event output
  logic [7:0] converter_status_secondary;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic pri_seen_r;
  logic pri_seen_nxt;
  logic sec_seen_r;
  logic sec_seen_nxt;
  logic event_r;
  logic event_nxt;
  logic any_flag;
  always_comb begin
    converter_status_secondary = PFSF_RST_VAL;
    converter_status_secondary[PFSF_B_UVD_HI] = uv_flags[0];
    converter_status_secondary[PFSF_B_UVD_HI-1] = uv_flags[1];
    converter_status_secondary[PFSF_B_UVD_LO] = uv_flags[2];
    converter_status_secondary[PFSF_B_PG_HI] = pg_r[0];
    converter_status_secondary[PFSF_B_PG_HI-1] = pg_r[1];
    converter_status_secondary[PFSF_B_PG_LO] = pg_r[2];
  end
  assign any_flag = (|fault_status_primary) ||
                    (|(converter_status_secondary & PFSF_RC_MASK2));
  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_pri) begin
      rdata_nxt = fault_status_primary;
    end else if (rd_sec) begin
      rdata_nxt = converter_status_secondary;
    end else if (i_rd) begin
      rdata_nxt = PFSF_RST_VAL;
    end
  end
  // event held until both read or flags all clear
  always_comb begin
    pri_seen_nxt = pri_seen_r || rd_pri;
    sec_seen_nxt = sec_seen_r || rd_sec;
    event_nxt = event_r;
    if (!event_r && any_flag) begin
      event_nxt = 1'b1;
      pri_seen_nxt = 1'b0;
      sec_seen_nxt = 1'b0;
    end else if (event_r && ((pri_seen_nxt && sec_seen_nxt) || !any_flag)) begin
      event_nxt = 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rdata_r <= PFSF_RST_VAL;
      pri_seen_r <= 1'b0;
      sec_seen_r <= 1'b0;
      event_r <= 1'b0;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
      pri_seen_r <= pri_seen_nxt;
      sec_seen_r <= sec_seen_nxt;
      event_r <= event_nxt;
    end
  end
  assign o_rdata = rdata_r;
  assign o_event_oe = event_r;
  assign o_event_o = 1'b0;
  // ==========================================================================
  // assertions
  property p_pri_read_value;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && rd_pri) |=> (o_rdata == $past(fault_status_primary));
  endproperty
  a_pri_read_value: assert property (p_pri_read_value)
    else $error("primary read data wrong");
  property p_brownout_set;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && i_brownout) |=> fault_status_primary[PFSF_B_BROWNOUT];
  endproperty
  a_brownout_set: assert property (p_brownout_set)
    else $error("brownout flag not set");
  property p_thermal_set;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && i_thermal_warning && i_thermal_shutdown)
        |=> (fault_status_primary[PFSF_B_HOT] && fault_status_primary[PFSF_B_TSD]);
  endproperty
  a_thermal_set: assert property (p_thermal_set)
    else $error("thermal flags not set");
  property p_lockout_set;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && i_lockout[0]) |=> fault_status_primary[PFSF_B_USB_LOCK];
  endproperty
  a_lockout_set: assert property (p_lockout_set)
    else $error("usb input lockout flag not set");
  property p_usb_set;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && i_usb_fault[1]) |=> fault_status_primary[PFSF_B_USB1];
  endproperty
  a_usb_set: assert property (p_usb_set)
    else $error("usb switch fault flag not set");
  property p_pri_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && rd_pri && fault_raw == 8'h00) |=> (fault_status_primary == 8'h00);
  endproperty
  a_pri_clear: assert property (p_pri_clear)
    else $error("primary flags not cleared by read");
  property p_event_release;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && event_r && !any_flag) |=> !o_event_oe;
  endproperty
  a_event_release: assert property (p_event_release)
    else $error("event output not released");
  property p_event_both_read;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && event_r && pri_seen_r && rd_sec) |=> !o_event_oe;
  endproperty
  a_event_both_read: assert property (p_event_both_read)
    else $error("event output held after both reads");
  property p_sec_top_zero;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && rd_sec) |=> (o_rdata[7:6] == 2'h0);
  endproperty
  a_sec_top_zero: assert property (p_sec_top_zero)
    else $error("unused secondary bits not zero");
  property p_pg_kept;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && rd_sec && (i_conv_pg == pg_r)) |=> (pg_r == $past(pg_r));
  endproperty
  a_pg_kept: assert property (p_pg_kept)
    else $error("power good changed by read");
  property p_sticky;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_ce && fault_status_primary[PFSF_B_TSD] && !rd_pri)
        |=> fault_status_primary[PFSF_B_TSD];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag lost without read");
  c_event: cover property (@(posedge i_sys_clk) $rose(o_event_oe));
  c_both_read: cover property (@(posedge i_sys_clk) rd_pri ##[1:20] rd_sec);
  c_refault: cover property (@(posedge i_sys_clk) rd_pri && i_brownout);
endmodule // pfsf_status
`default_nettype wire

// ==== tb/pfsf_host.sv ====
// pfsf_host: host model reading the status bank through the read strobe
// assumes: shares i_sys_clk with the bank, reads are issued by task calls
`timescale 1ns/1ps
`default_nettype none
module pfsf_host (
  input wire logic i_sys_clk, // system clock
  input wire logic [7:0] i_rdata, // read data from the bank
  output logic o_rd, // read strobe
  output logic [7:0] o_addr // register offset
);
  // ==========================================================================
  // idle levels
  initial begin
    o_rd = 1'b0;
    o_addr = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_addr <= ~a; // released offset shows no stale value
    @(posedge i_sys_clk);
    #1;
    d = i_rdata;
  endtask
endmodule // pfsf_host
`default_nettype wire

// ==== tb/power_fault_status_flags_tb.sv ====
// power_fault_status_flags_tb: self-checking bench of the status flag bank
// assumes: pfsf_host issues the reads, fault levels come from this bench
`timescale 1ns/1ps
`default_nettype none
module power_fault_status_flags_tb;
  import pfsf_pkg::*;
  logic sys_clk, sys_rst, ce, rd, oe, oo;
  logic [7:0] flt, addr, rdata, d;
  logic [2:0] uv, pg;
  int num_errors, n_checks, cyc;
  // ==========================================================================
  // design and host
  pfsf_status pfsf_status_inst (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_ce(ce),
    .i_rd(rd), .i_addr(addr), .i_brownout(flt[7]), .i_thermal_shutdown(flt[6]),
    .i_thermal_warning(flt[5]), .i_lockout(flt[4:2]), .i_usb_fault(flt[1:0]),
    .i_conv_uv(uv), .i_conv_pg(pg), .o_rdata(rdata), .o_event_oe(oe), .o_event_o(oo));
  pfsf_host pfsf_host_inst (.i_sys_clk(sys_clk), .i_rdata(rdata), .o_rd(rd), .o_addr(addr));
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    pfsf_host_inst.rd(a, d);
    chk(nm, e, d);
  endtask
  // one-cycle fault pulse, then let flags and event settle
  task automatic pulse(input logic [7:0] p, input logic [2:0] u);
    @(posedge sys_clk);
    flt <= p;
    uv <= u;
    @(posedge sys_clk);
    flt <= 8'h00;
    uv <= 3'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    flt = 8'h00;
    ce = 1'b1;
    uv = 3'h0;
    pg = 3'h0;
    cyc = 0;
    num_errors = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc("primary reset", PFSF_OFS_PRIMARY, PFSF_RST_VAL);
    rdc("secondary reset", PFSF_OFS_SECONDARY, PFSF_RST_VAL);
    chk("event idle", 8'h00, {7'h00, oe});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 3'h0);
      chk("event set", 8'h01, {7'h00, oe});
      chk("event level", 8'h00, {7'h00, oo});
      rdc("primary flag", PFSF_OFS_PRIMARY, 8'h01 << i);
      rdc("primary clear", PFSF_OFS_PRIMARY, 8'h00);
    end
    // both thermal flags raised together
    pulse(8'h60, 3'h0);
    rdc("thermal pair", PFSF_OFS_PRIMARY, 8'h60);
    $display("test primary done");
    @(posedge sys_clk);
    pg <= 3'b011;
    for (int k = 0; k < 3; k++) begin
      pulse(8'h00, 3'b001 << k);
      rdc("secondary uv", PFSF_OFS_SECONDARY, (8'h20 >> k) | 8'h06);
      rdc("secondary pg", PFSF_OFS_SECONDARY, 8'h06);
    end
    $display("test secondary done");
    @(posedge sys_clk);
    flt <= 8'h80;
    rdc("persist one", PFSF_OFS_PRIMARY, 8'h80);
    rdc("persist two", PFSF_OFS_PRIMARY, 8'h80);
    @(posedge sys_clk);
    flt <= 8'h00;
    rdc("persist last", PFSF_OFS_PRIMARY, 8'h80);
    rdc("persist gone", PFSF_OFS_PRIMARY, 8'h00);
    $display("test persist done");
    pulse(8'h40, 3'h0);
    rdc("unmapped", 8'h04, 8'h00);
    rdc("offset zero", 8'h00, 8'h00);
    rdc("no side effect", PFSF_OFS_PRIMARY, 8'h40);
    $display("test unmapped done");
    pulse(8'h01, 3'b001);
    rdc("both primary", PFSF_OFS_PRIMARY, 8'h01);
    chk("event held", 8'h01, {7'h00, oe});
    rdc("both secondary", PFSF_OFS_SECONDARY, 8'h26);
    chk("event released", 8'h00, {7'h00, oe});
    $display("test event done");
    // clock enable low freezes the flags
    @(posedge sys_clk);
    ce <= 1'b0;
    pulse(8'h80, 3'b001);
    @(posedge sys_clk);
    ce <= 1'b1;
    rdc("frozen primary", PFSF_OFS_PRIMARY, PFSF_RST_VAL);
    rdc("frozen secondary", PFSF_OFS_SECONDARY, 8'h06);
    chk("frozen event", 8'h00, {7'h00, oe});
    $display("test enable done");
    // reset in mid-run clears set flags and the event
    pulse(8'h80, 3'b001);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc("rerst primary", PFSF_OFS_PRIMARY, PFSF_RST_VAL);
    chk("rerst event", 8'h00, {7'h00, oe});
    rdc("rerst secondary", PFSF_OFS_SECONDARY, 8'h06);
    $display("test reset again done");
    final_report();
  end
endmodule // power_fault_status_flags_tb
`default_nettype wire
